/* File: include/facl_pkg.sv */
// constants for the frame locked audio clock generator
// Contract
// - clocks per field is 18 bits across three bytes
// - nominal increment is 22 bits across three bytes, scaled by 2^23
// - bit clock equals master input over twice divider plus one
// - word select equals bit clock over twice word divider
// - without analog pll the digital clock drives master output
// - 384 and 512 ratios are unsupported without analog pll
// - control bit 7 selects analog pll clock for master output
// - in analog mode clocks per field scaled by (4-range)/16
// - in analog mode increment scaled by (4-range)/16
// - control bit 6 sets analog pll centre, 36 or 27 mhz
// - analog mode: 512x used directly, others via bit divider; the code only flags 512x in status bit 1 and always uses the bit divider
// - audio clock stays locked to the video field rate
// - master clock synthesised from the crystal clock
// - control bit 3 opens the loop when one
// - control bit 2 selects external vertical reference
// - control bit 1 picks word select on rising bit clock edges
// - control bit 0 picks bit clock on rising master input edges
package facl_pkg;
  localparam int          ACC_W          = 23;
  localparam int          INC_W          = 22;
  localparam int          CPF_W          = 18;
  localparam int          DIV_W          = 6;
  localparam int          CORR_W         = 24;
  localparam int          GAIN_SH        = 4;
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  IDX_CPF_LO     = 8'h30;
  localparam logic [7:0]  IDX_CPF_MID    = 8'h31;
  localparam logic [7:0]  IDX_CPF_HI     = 8'h32;
  localparam logic [7:0]  IDX_INC_LO     = 8'h34;
  localparam logic [7:0]  IDX_INC_MID    = 8'h35;
  localparam logic [7:0]  IDX_INC_HI     = 8'h36;
  localparam logic [7:0]  IDX_BIT_DIV    = 8'h38;
  localparam logic [7:0]  IDX_WORD_DIV   = 8'h39;
  localparam logic [7:0]  IDX_CTRL       = 8'h3a;
  localparam logic [7:0]  IDX_STATUS     = 8'h3b;
  localparam int          CTL_ANALOG_EN  = 7;
  localparam int          CTL_RANGE      = 6;
  localparam int          CTL_LOOP_OPEN  = 3;
  localparam int          CTL_VREF_EXT   = 2;
  localparam int          CTL_WS_PHASE   = 1;
  localparam int          CTL_BC_PHASE   = 0;
  localparam logic [17:0] RST_CPF        = 18'h00000;
  localparam logic [21:0] RST_INC        = 22'h000000;
  localparam logic [5:0]  RST_DIV        = 6'h00;
  localparam logic [7:0]  RST_CTRL       = 8'h00;
  localparam logic [13:0] RATIO_384      = 14'h0180;
  localparam logic [13:0] RATIO_512      = 14'h0200;
endpackage : facl_pkg

/* File: core/facl_div.sv */
// edge counting binary divider producing a toggling clock level
module facl_div #(
  parameter int DIV_W = 6
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             edge_en,
  input  wire logic             hold,
  input  wire logic [DIV_W-1:0] terminal,
  output logic                  clk_out,
  output logic                  toggle
);
  logic [DIV_W-1:0] cnt_r;

  // clk_out toggles after terminal+1 counted edges, so its period is
  // 2*(terminal+1) edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= '0;
      clk_out <= 1'b0;
      toggle  <= 1'b0;
    end else begin
      toggle <= 1'b0;
      if (hold) begin
        cnt_r <= '0;
      end else if (edge_en) begin
        if (cnt_r >= terminal) begin
          cnt_r   <= '0;
          clk_out <= ~clk_out;
          toggle  <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule : facl_div

/* File: core/facl_top.sv */
// frame locked audio master clock, bit clock and word select generator
module facl_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        internal_vsync,
  input  wire logic        external_vsync,
  input  wire logic        analog_pll_clk,
  input  wire logic        master_clock_in,
  output logic             master_clock_out,
  output logic             analog_pll_ref,
  output logic             analog_pll_enable,
  output logic             analog_pll_range,
  output logic             serial_bit_clock,
  output logic             word_select_clock
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [facl_pkg::CPF_W-1:0] clocks_per_field_r;
  logic [facl_pkg::INC_W-1:0] nominal_increment_r;
  logic [facl_pkg::DIV_W-1:0] bit_clock_div_r;
  logic [facl_pkg::DIV_W-1:0] word_select_div_r;
  logic [7:0]                 ctrl_r;
  logic                       unsupported_r;
  logic                       direct_512_r;
  logic                       locked_r;
  logic                       field_seen_r;

  logic       bus_req;
  logic       wr_en;
  logic [7:0] idx;
  logic [7:0] wbyte;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[9:2];
  assign wbyte   = wb_dat_i[7:0];

  // register writes take effect on the edge that raises ack
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clocks_per_field_r  <= facl_pkg::RST_CPF;
      nominal_increment_r <= facl_pkg::RST_INC;
      bit_clock_div_r     <= facl_pkg::RST_DIV;
      word_select_div_r   <= facl_pkg::RST_DIV;
      ctrl_r              <= facl_pkg::RST_CTRL;
    end else if (wr_en) begin
      case (idx)
        facl_pkg::IDX_CPF_LO:   clocks_per_field_r[7:0]   <= wbyte;
        facl_pkg::IDX_CPF_MID:  clocks_per_field_r[15:8]  <= wbyte;
        facl_pkg::IDX_CPF_HI:   clocks_per_field_r[17:16] <= wbyte[1:0];
        facl_pkg::IDX_INC_LO:   nominal_increment_r[7:0]  <= wbyte;
        facl_pkg::IDX_INC_MID:  nominal_increment_r[15:8] <= wbyte;
        facl_pkg::IDX_INC_HI:   nominal_increment_r[21:16] <= wbyte[5:0];
        facl_pkg::IDX_BIT_DIV:  bit_clock_div_r   <= wbyte[5:0];
        facl_pkg::IDX_WORD_DIV: word_select_div_r <= wbyte[5:0];
        facl_pkg::IDX_CTRL:     ctrl_r <= wbyte;
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      facl_pkg::IDX_CPF_LO:   read_mux = clocks_per_field_r[7:0];
      facl_pkg::IDX_CPF_MID:  read_mux = clocks_per_field_r[15:8];
      facl_pkg::IDX_CPF_HI:   read_mux = {6'h00, clocks_per_field_r[17:16]};
      facl_pkg::IDX_INC_LO:   read_mux = nominal_increment_r[7:0];
      facl_pkg::IDX_INC_MID:  read_mux = nominal_increment_r[15:8];
      facl_pkg::IDX_INC_HI:   read_mux = {2'h0, nominal_increment_r[21:16]};
      facl_pkg::IDX_BIT_DIV:  read_mux = {2'h0, bit_clock_div_r};
      facl_pkg::IDX_WORD_DIV: read_mux = {2'h0, word_select_div_r};
      facl_pkg::IDX_CTRL:     read_mux = ctrl_r;
      facl_pkg::IDX_STATUS:
        read_mux = {4'h0, field_seen_r, locked_r, direct_512_r,
                    unsupported_r};
      default:                read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // one wait state: ack one cycle after the request, dropped the next
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h000000, read_mux(idx)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control decode
  logic loop_open;
  logic vref_ext;
  logic ws_phase;
  logic bc_phase;
  logic analog_en;

  assign analog_en = ctrl_r[facl_pkg::CTL_ANALOG_EN];
  assign loop_open = ctrl_r[facl_pkg::CTL_LOOP_OPEN];
  assign vref_ext  = ctrl_r[facl_pkg::CTL_VREF_EXT];
  assign ws_phase  = ctrl_r[facl_pkg::CTL_WS_PHASE];
  assign bc_phase  = ctrl_r[facl_pkg::CTL_BC_PHASE];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      analog_pll_enable <= 1'b0;
      analog_pll_range  <= 1'b0;
    end else begin
      analog_pll_enable <= analog_en;
      analog_pll_range  <= ctrl_r[facl_pkg::CTL_RANGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field reference
  logic vref_sel;
  logic vref_prev_r;
  logic field_tick;

  assign vref_sel   = vref_ext ? external_vsync : internal_vsync;
  assign field_tick = vref_sel & ~vref_prev_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vref_prev_r <= 1'b0;
    end else begin
      vref_prev_r <= vref_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase accumulator on the crystal clock with per field correction
  logic signed [facl_pkg::CORR_W-1:0] corr_r;
  logic signed [facl_pkg::CORR_W-1:0] err;
  logic [facl_pkg::ACC_W-1:0]         acc_r;
  logic [facl_pkg::ACC_W-1:0]         step;
  logic [facl_pkg::CPF_W-1:0]         cycle_cnt_r;
  logic                               acc_msb_prev_r;
  logic                               dto_rise;

  // in analog mode software already scales both values by (4-range)/16,
  // so the accumulator runs the same way in both modes
  assign step = facl_pkg::ACC_W'({1'b0, nominal_increment_r} +
                                 facl_pkg::ACC_W'(corr_r));
  assign dto_rise = acc_r[facl_pkg::ACC_W-1] & ~acc_msb_prev_r;
  assign err = facl_pkg::CORR_W'($signed({1'b0, clocks_per_field_r}) -
                                 $signed({1'b0, cycle_cnt_r}));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r          <= '0;
      acc_msb_prev_r <= 1'b0;
    end else begin
      acc_r          <= acc_r + step;
      acc_msb_prev_r <= acc_r[facl_pkg::ACC_W-1];
    end
  end

  // cycles of the synthesised clock counted over one field
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycle_cnt_r <= '0;
    end else if (field_tick) begin
      cycle_cnt_r <= dto_rise ? 18'h00001 : 18'h00000;
    end else if (dto_rise) begin
      cycle_cnt_r <= cycle_cnt_r + 1'b1;
    end
  end

  // integrating loop; gain kept low since the lock is meant to be slow,
  // trading capture time for low wander
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      corr_r       <= '0;
      locked_r     <= 1'b0;
      field_seen_r <= 1'b0;
    end else if (field_tick) begin
      field_seen_r <= 1'b1;
      if (field_seen_r && !loop_open) begin
        corr_r   <= corr_r + (err >>> facl_pkg::GAIN_SH);
        locked_r <= (err == '0);
      end else if (loop_open) begin
        locked_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master clock pin and analog pll reference
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      analog_pll_ref   <= 1'b0;
      master_clock_out <= 1'b0;
    end else begin
      analog_pll_ref <= acc_r[facl_pkg::ACC_W-1];
      if (analog_en) begin
        master_clock_out <= analog_pll_clk;
      end else begin
        master_clock_out <= acc_r[facl_pkg::ACC_W-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ratio checks: master/fs = 2*(bit div+1) * 2*word div
  logic [13:0] ratio;
  logic [6:0]  bc_half;

  assign bc_half = {1'b0, bit_clock_div_r} + 7'h01;
  assign ratio   = 14'({bc_half, 1'b0} * {word_select_div_r, 1'b0});

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      unsupported_r <= 1'b0;
      direct_512_r  <= 1'b0;
    end else begin
      unsupported_r <= ~analog_en & ((ratio == facl_pkg::RATIO_384) |
                       (ratio == facl_pkg::RATIO_512));
      direct_512_r  <= analog_en & (ratio == facl_pkg::RATIO_512);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit clock and word select dividers from the returned master clock
  logic mci_prev_r;
  logic mci_edge;
  logic bc_toggle;
  logic bc_level;
  logic ws_edge;
  logic ws_hold;

  // master clock input takes the board loop of the master output or an
  // external clock on this pin; both dividers count whatever edges arrive
  assign mci_edge = bc_phase ? (master_clock_in & ~mci_prev_r)
                             : (~master_clock_in & mci_prev_r);
  assign ws_edge  = bc_toggle & (bc_level == ws_phase);
  assign ws_hold  = (word_select_div_r == 6'h00);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mci_prev_r <= 1'b0;
    end else begin
      mci_prev_r <= master_clock_in;
    end
  end

  facl_div #(
    .DIV_W (facl_pkg::DIV_W)
  ) u_bit_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .edge_en  (mci_edge),
    .hold     (1'b0),
    .terminal (bit_clock_div_r),
    .clk_out  (bc_level),
    .toggle   (bc_toggle)
  );

  facl_div #(
    .DIV_W (facl_pkg::DIV_W)
  ) u_word_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .edge_en  (ws_edge),
    .hold     (ws_hold),
    .terminal (word_select_div_r - 6'h01),
    .clk_out  (word_select_clock),
    .toggle   ()
  );

  assign serial_bit_clock = bc_level;

endmodule : facl_top

/* File: tb/facl_ext_pll.sv */
// far side model: returned master clock and the analog pll clock
module facl_ext_pll (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic loop_back,
  input  wire logic mclk_out,
  input  wire logic pll_on,
  output logic      mclk_in,
  output logic      pll_clk
);
  logic [3:0] ext_r;
  logic [1:0] pll_r;
  // off loop back this acts as a slow external pll, well under core_clk/2
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_r   <= 4'h0;
      mclk_in <= 1'b0;
    end else if (loop_back) begin
      mclk_in <= mclk_out;
    end else begin
      ext_r <= (ext_r == 4'h8) ? 4'h0 : ext_r + 4'h1;
      if (ext_r == 4'h8) begin
        mclk_in <= ~mclk_in;
      end
    end
  end
  // a powered down pll flickers, so a wrong clock select is seen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pll_r   <= 2'h0;
      pll_clk <= 1'b0;
    end else if (!pll_on) begin
      pll_clk <= ~pll_clk;
    end else begin
      pll_r <= (pll_r == 2'h2) ? 2'h0 : pll_r + 2'h1;
      if (pll_r == 2'h2) begin
        pll_clk <= ~pll_clk;
      end
    end
  end
endmodule : facl_ext_pll

/* File: tb/facl_sva.sv */
// port checker for the frame locked audio clock block
module facl_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        master_clock_in,
  input wire logic        master_clock_out,
  input wire logic        analog_pll_ref,
  input wire logic        analog_pll_enable,
  input wire logic        analog_pll_range,
  input wire logic        serial_bit_clock,
  input wire logic        word_select_clock
);
  logic [7:0] ctl_r;
  logic [3:0] ctl_age_r, mci_age_r, sbc_age_r;
  logic       mci_q_r, sbc_q_r;
  wire wr_ctl = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                & (wb_adr_i[9:2] == facl_pkg::IDX_CTRL);
  wire mci_edge = master_clock_in != mci_q_r && master_clock_in == ctl_r[0];
  wire sbc_edge = serial_bit_clock != sbc_q_r && serial_bit_clock == ctl_r[1];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r     <= 8'h00;
      ctl_age_r <= 4'h0;
    end else if (wr_ctl) begin
      ctl_r     <= wb_dat_i[7:0];
      ctl_age_r <= 4'h0;
    end else if (ctl_age_r != 4'hf) begin
      ctl_age_r <= ctl_age_r + 4'h1;
    end
  end
  // cycles since the last pin edge of the selected polarity
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mci_q_r   <= 1'b0;
      sbc_q_r   <= 1'b0;
      mci_age_r <= 4'hf;
      sbc_age_r <= 4'hf;
    end else begin
      mci_q_r   <= master_clock_in;
      sbc_q_r   <= serial_bit_clock;
      mci_age_r <= mci_edge ? 4'h0 : mci_age_r + {3'h0, mci_age_r != 4'hf};
      sbc_age_r <= sbc_edge ? 4'h0 : sbc_age_r + {3'h0, sbc_age_r != 4'hf};
    end
  end
  ////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
    wb_ack_o) else $error("no ack one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  en_copy_a: assert property (ctl_age_r >= 4'h3 |->
    analog_pll_enable == ctl_r[7]) else $error("pll enable wrong");
  range_copy_a: assert property (ctl_age_r >= 4'h3 |->
    analog_pll_range == ctl_r[6]) else $error("pll range wrong");
  raw_mclk_a: assert property ((ctl_age_r == 4'hf && !ctl_r[7]) |->
    master_clock_out == analog_pll_ref) else $error("master clock not raw");
  bit_cause_a: assert property (($changed(serial_bit_clock) &&
    ctl_age_r == 4'hf) |-> mci_age_r <= 4'h6)
    else $error("bit clock edge without master edge");
  ws_cause_a: assert property (($changed(word_select_clock) &&
    ctl_age_r == 4'hf) |-> (sbc_age_r <= 4'h6) or (##[1:3] sbc_edge))
    else $error("word select edge without bit clock edge");
  cover property (wr_ctl && wb_dat_i[7]);
  cover property (ctl_age_r == 4'hf && $changed(word_select_clock));
  cover property (analog_pll_enable && $rose(master_clock_out));
endmodule : facl_chk

bind facl_top facl_chk i_chk (
  .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .master_clock_in, .master_clock_out, .analog_pll_ref,
  .analog_pll_enable, .analog_pll_range, .serial_bit_clock, .word_select_clock
);

/* File: tb/tb.sv */
// self-checking bench for the frame locked audio clock block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VPER = 4096;
  logic        core_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic        internal_vsync, external_vsync, analog_pll_clk, master_clock_in;
  logic        master_clock_out, analog_pll_ref, analog_pll_enable;
  logic        analog_pll_range, serial_bit_clock, word_select_clock;
  logic        loop_back, mo_q, iv_q, mi_q, sb_q, ws_q;
  logic [7:0]  rd, ctl;
  int          miscompares = 0, n_tests = 0, seed = 8777, vcnt = 0, n_exp;
  int          fld_cnt = 0, last_fld = 0, m_cnt = 0, s_cnt = 0;
  // link checks stay off until the first configuration is in place
  int          sb_on = -64, ws_on = -64, bd = 0, wd = 0;
  logic [7:0]  idx_t [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38,
                             8'h39, 8'h3a};
  logic [7:0]  msk_t [9] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h3f,
                             8'h3f, 8'hcf};
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
  facl_top i_dut (
    .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .internal_vsync, .external_vsync,
    .analog_pll_clk, .master_clock_in, .master_clock_out, .analog_pll_ref,
    .analog_pll_enable, .analog_pll_range, .serial_bit_clock, .word_select_clock
  );
  facl_ext_pll i_pll (
    .core_clk, .resetn, .loop_back, .mclk_out(master_clock_out),
    .pll_on(analog_pll_enable), .mclk_in(master_clock_in),
    .pll_clk(analog_pll_clk)
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  // the unselected reference carries noise so a wrong select is seen
  always @(posedge core_clk) begin
    vcnt <= (vcnt == VPER - 1) ? 0 : vcnt + 1;
    internal_vsync <= (vcnt < 4);
    external_vsync <= 1'($random(seed));
    mo_q <= master_clock_out;
    iv_q <= internal_vsync;
    mi_q <= master_clock_in;
    sb_q <= serial_bit_clock;
    ws_q <= word_select_clock;
    if (master_clock_out && !mo_q) fld_cnt++;
    if (internal_vsync && !iv_q) begin
      last_fld = fld_cnt;
      fld_cnt = 0;
    end
    if (master_clock_in != mi_q && master_clock_in == ctl[0]) m_cnt++;
    if (serial_bit_clock != sb_q && serial_bit_clock == ctl[1]) s_cnt++;
    if (serial_bit_clock != sb_q) begin
      if (sb_on > 2) `CHK(m_cnt, bd + 1)
      m_cnt = 0;
      sb_on++;
    end
    if (word_select_clock != ws_q) begin
      if (ws_on > 2) `CHK(s_cnt, wd)
      s_cnt = 0;
      ws_on++;
    end
  end
  ////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic s0);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= {3'($random(seed)), s0};
    wb_dat_i <= {24'($random(seed)), d};
    do begin
      @(posedge core_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t == 50) miscompares++;
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic cfg(input logic [21:0] inc, input logic [17:0] cpf,
                     input logic [7:0] c);
    logic [7:0] v [9];
    // dividers and phases change mid write, so no link check meanwhile
    sb_on = -64;
    ws_on = -64;
    v = '{cpf[7:0], cpf[15:8], {6'h0, cpf[17:16]}, inc[7:0], inc[15:8],
          {2'h0, inc[21:16]}, 8'(bd), 8'(wd), c};
    for (int i = 0; i < 9; i++) wb(1'b1, idx_t[i], v[i], 1'b1);
    ctl = c;
    sb_on = 0;
    ws_on = 0;
  endtask : cfg
  task automatic test_done;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #(8 * 90000);
    miscompares++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, loop_back} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {internal_vsync, external_vsync, ctl} = '0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, idx_t[i], 8'h00, 1'b1);
      `CHK(rd, 8'h00)
      r = $random(seed);
      wb(1'b1, idx_t[i], r[7:0], 1'b1);
      wb(1'b1, idx_t[i], ~r[7:0], 1'b0);
      wb(1'b0, idx_t[i], 8'h00, 1'b1);
      `CHK(rd & msk_t[i], r[7:0] & msk_t[i])
    end
    wb(1'b1, 8'h33, 8'hff, 1'b1);
    wb(1'b0, 8'h33, 8'h00, 1'b1);
    `CHK(rd, 8'h00)
    for (int k = 0; k < 4; k++) begin
      bd = (k < 1) ? 1 : 3;
      wd = (k < 1) ? 48 : 32 - (k == 3);
      cfg(22'h100000, 18'h00200, {k == 2, 7'h00});
      wb(1'b0, 8'h3b, 8'h00, 1'b1);
      `CHK(rd[0], 1'((4 * (bd + 1) * wd) inside {384, 512} && k != 2))
      `CHK(rd[1], 1'(k == 2))
    end
    // open loop, closed loop, then the analog pll clock on the pin
    bd = 2;
    wd = 3;
    for (int k = 0; k < 3; k++) begin
      cfg(22'h100000, (k == 0) ? 18'd600 : 18'd512,
          (k == 2) ? 8'h80 : {4'h0, k == 0, 3'h0});
      repeat (4 * VPER) @(posedge core_clk);
      n_exp = (k == 2) ? VPER / 6 : int'((longint'(VPER) << 20) >> 23);
      `CHK(1'(last_fld >= n_exp - 1 && last_fld <= n_exp + 1), 1'b1)
      wb(1'b0, 8'h3b, 8'h00, 1'b1);
      `CHK(rd[3:0], {1'b1, k != 0, 2'b00})
    end
    for (int k = 0; k < 4; k++) begin
      bd = $random(seed) & 3;
      wd = 1 + ($random(seed) & 3);
      loop_back <= (k == 3);
      cfg(22'h100000, 18'd512, 8'(k));
      repeat (3000) @(posedge core_clk);
      `CHK(1'(ws_on > 3), 1'b1)
    end
    test_done();
  end
endmodule : tb
